// [core/flag_bit_cell.sv]
// one sticky reset-cause flag with init, hardware event and software write
`timescale 1ns/1ps
module flag_bit_cell #(
  parameter logic INIT_VALUE = 1'b1,
  parameter logic EVT_VALUE  = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic initPulse,
  input  wire logic hwEvent,
  input  wire logic wrEn,
  input  wire logic wrBit,
  output logic      flagValue
);
  typedef struct packed {
    logic value;
  } flag_state_t;

  flag_state_t state;
  flag_state_t next_state;

  // init beats the hardware event, the event beats a software write
  always_comb begin
    next_state = state;
    if (initPulse) begin
      next_state.value = INIT_VALUE;
    end else if (hwEvent) begin
      next_state.value = EVT_VALUE;
    end else if (wrEn) begin
      next_state.value = wrBit;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{value: INIT_VALUE};
    end else begin
      state <= next_state;
    end
  end

  assign flagValue = state.value;
endmodule

// [core/power_ctrl_pkg.sv]
// constants and types shared by the power-control register bank
package power_ctrl_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam int              IDX_W           = 12;
  localparam logic [11:0]     BOR_CTRL_IDX    = 12'h811;
  localparam logic [11:0]     CAUSE_FLAGS_IDX = 12'h813;
  localparam logic [11:0]     MEMORY_VIOLATION_FLAG_STATUS_IDX = 12'h814;
  localparam int              IDX_LSB         = 2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int              SW_BOR_EN_BIT   = 7;
  localparam int              BOR_READY_BIT   = 0;
  localparam int              STACK_OVF_BIT   = 7;
  localparam int              STACK_UNF_BIT   = 6;
  localparam int              WIN_VIOL_BIT    = 5;
  localparam int              WDT_TMO_BIT     = 4;
  localparam int              PIN_RST_BIT     = 3;
  localparam int              RST_INSTR_BIT   = 2;
  localparam int              POWER_ON_BIT    = 1;
  localparam int              BROWNOUT_BIT    = 0;
  localparam int              MEMORY_VIOLATION_FLAG_BIT        = 1;
  localparam int              FLAG_W          = 8;
  localparam int              MODE_W          = 2;

  // ****************************************
  // values after reset and hardware event values
  // ****************************************
  localparam logic            SW_BOR_EN_INIT  = 1'b1;
  localparam logic [7:0]      FLAGS_INIT      = 8'h3D;  // por flag 0, brown-out flag taken as 1
  localparam logic [7:0]      FLAGS_EVT_VALUE = 8'hC0;  // stack flags set, others clear
  localparam logic [7:0]      FLAGS_BOR_INIT  = 8'hFC;  // reinitialised by a brown-out reset
  localparam logic            MEMORY_VIOLATION_FLAG_INIT       = 1'b1;
  localparam logic            MEMORY_VIOLATION_FLAG_EVT_VALUE  = 1'b0;
  localparam logic [1:0]      MODE_SW_CTRL    = 2'h1;

  // ****************************************
  // bus encodings
  // ****************************************
  localparam logic [1:0]      HTRANS_NONSEQ   = 2'h2;
  localparam logic            HRESP_OKAY      = 1'b0;
  localparam logic [31:0]     RDATA_ZERO      = 32'h0000_0000;

  typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_FLAGS, SEL_MEMORY_VIOLATION_FLAG} reg_sel_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} bus_state_t;

endpackage

// [core/reset_cause_status_regs.sv]
// power-control register bank: brown-out control and reset-cause flags
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module reset_cause_status_regs (
  input  wire logic                              core_clk,
  input  wire logic                              resetn,
  // ahb-lite slave
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic      [31:0]                       hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  // configuration and analog status
  input  wire logic [power_ctrl_pkg::MODE_W-1:0] brownoutModeConfig,
  input  wire logic                              brownoutArmed,
  input  wire logic                              externalResetPinN,
  // reset-cause events, one-cycle pulses
  input  wire logic                              brownoutResetEvt,
  input  wire logic                              stackOverflowEvt,
  input  wire logic                              stackUnderflowEvt,
  input  wire logic                              windowViolationEvt,
  input  wire logic                              watchdogTimeoutEvt,
  input  wire logic                              resetInstrEvt,
  input  wire logic                              memViolationEvt,
  // to the brown-out detector
  output logic                                   brownoutDetectEnable,
  output logic                                   brownoutCircuitReady
);
  import power_ctrl_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    bus_state_t  busState;
    reg_sel_t    regSel;
    logic        swBrownoutEnable;
    logic        pinPrev;
    logic        detectEnable;
    logic        circuitReady;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } main_state_t;

  main_state_t          state;
  main_state_t          next_state;
  logic [1:0]           syncLevels;
  logic                 armedSync;
  logic                 pinSync;
  logic                 pinFall;
  logic                 addrAccept;
  reg_sel_t             addrSel;
  logic                 wrCtrl;
  logic                 wrFlags;
  logic                 wrMemv;
  logic [FLAG_W-1:0]    flagEvents;
  logic [FLAG_W-1:0]    flagInit;
  logic [FLAG_W-1:0]    flags;
  logic                 memvFlag;
  logic [31:0]          readWord;

  // ****************************************
  // pin and analog synchronisers
  // ****************************************
  // both come from outside the clock domain
  sync_two_flop #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .asyncIn  ({brownoutArmed, externalResetPinN}),
    .syncOut  (syncLevels)
  );

  // reset pin low edge marks an external reset
  always_comb begin
    armedSync = syncLevels[1];
    pinSync   = syncLevels[0];
    pinFall   = state.pinPrev & ~pinSync;
  end

  // ****************************************
  // address decode
  // ****************************************
  // only word-aligned addresses in the low index window decode
  always_comb begin
    addrSel = SEL_NONE;
    if (haddr[31:IDX_LSB+IDX_W] == '0 && haddr[IDX_LSB-1:0] == '0) begin
      case (haddr[IDX_LSB+IDX_W-1:IDX_LSB])
        BOR_CTRL_IDX:    addrSel = SEL_CTRL;
        CAUSE_FLAGS_IDX: addrSel = SEL_FLAGS;
        MEMORY_VIOLATION_FLAG_STATUS_IDX: addrSel = SEL_MEMORY_VIOLATION_FLAG;
        default:         addrSel = SEL_NONE;
      endcase
    end
  end

  // a new transfer is taken while the bus is ready
  always_comb begin
    addrAccept = hsel & hready & htrans[1] & state.hreadyout;
  end

  // write strobes live in the data phase, when hwdata stands
  always_comb begin
    wrCtrl  = (state.busState == BUS_WRITE) && (state.regSel == SEL_CTRL);
    wrFlags = (state.busState == BUS_WRITE) && (state.regSel == SEL_FLAGS);
    wrMemv  = (state.busState == BUS_WRITE) && (state.regSel == SEL_MEMORY_VIOLATION_FLAG);
  end

  // ****************************************
  // reset-cause flags
  // ****************************************
  // event vector in bit order of the flag register
  always_comb begin
    flagEvents                = '0;
    flagEvents[STACK_OVF_BIT] = stackOverflowEvt;
    flagEvents[STACK_UNF_BIT] = stackUnderflowEvt;
    flagEvents[WIN_VIOL_BIT]  = windowViolationEvt;
    flagEvents[WDT_TMO_BIT]   = watchdogTimeoutEvt;
    flagEvents[PIN_RST_BIT]   = pinFall;
    flagEvents[RST_INSTR_BIT] = resetInstrEvt;
    flagEvents[BROWNOUT_BIT]  = brownoutResetEvt;
    flagInit                  = FLAGS_BOR_INIT & {FLAG_W{brownoutResetEvt}};
  end

  // power-on flag has no event: only resetn or a software write to the flag register clears it
  generate
    for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
      flag_bit_cell #(
        .INIT_VALUE (FLAGS_INIT[i]),
        .EVT_VALUE  (FLAGS_EVT_VALUE[i])
      ) u_cell (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .initPulse (flagInit[i]),
        .hwEvent   (flagEvents[i]),
        .wrEn      (wrFlags),
        .wrBit     (hwdata[i]),
        .flagValue (flags[i])
      );
    end
  endgenerate

  // memory violation flag, reinitialised by a brown-out reset
  flag_bit_cell #(
    .INIT_VALUE (MEMORY_VIOLATION_FLAG_INIT),
    .EVT_VALUE  (MEMORY_VIOLATION_FLAG_EVT_VALUE)
  ) u_memory_violation_flag (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .initPulse (brownoutResetEvt),
    .hwEvent   (memViolationEvt),
    .wrEn      (wrMemv),
    .wrBit     (hwdata[MEMORY_VIOLATION_FLAG_BIT]),
    .flagValue (memvFlag)
  );

  // ****************************************
  // read data
  // ****************************************
  // unused bit positions stay zero, unmapped words read zero
  always_comb begin
    readWord = RDATA_ZERO;
    case (state.regSel)
      SEL_CTRL: begin
        readWord[SW_BOR_EN_BIT] = state.swBrownoutEnable;
        readWord[BOR_READY_BIT] = state.circuitReady;
      end
      SEL_FLAGS: begin
        readWord[FLAG_W-1:0] = flags;
      end
      SEL_MEMORY_VIOLATION_FLAG: begin
        readWord[MEMORY_VIOLATION_FLAG_BIT] = memvFlag;
      end
      default: begin
        readWord = RDATA_ZERO;
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  // reads take one wait state so a write just before is visible
  always_comb begin
    next_state         = state;
    next_state.pinPrev = pinSync;
    next_state.hresp   = HRESP_OKAY;
    case (state.busState)
      BUS_READ_WAIT: begin
        next_state.hrdata    = readWord;
        next_state.hreadyout = 1'b1;
        next_state.busState  = BUS_READ_DONE;
      end
      default: begin
        next_state.busState = BUS_IDLE;
        next_state.regSel   = SEL_NONE;
        if (addrAccept) begin
          next_state.regSel = addrSel;
          if (hwrite) begin
            next_state.busState = BUS_WRITE;
          end else begin
            next_state.busState  = BUS_READ_WAIT;
            next_state.hreadyout = 1'b0;
          end
        end
      end
    endcase
    // software enable: brown-out reset reinitialises, writes store bit 7
    if (brownoutResetEvt) begin
      next_state.swBrownoutEnable = SW_BOR_EN_INIT;
    end else if (wrCtrl) begin
      next_state.swBrownoutEnable = hwdata[SW_BOR_EN_BIT];
    end
    // the enable only matters in software-controlled mode
    if (brownoutModeConfig == MODE_SW_CTRL) begin
      next_state.detectEnable = state.swBrownoutEnable;
    end else begin
      next_state.detectEnable = brownoutModeConfig[1];
    end
    // not ready while disabled or still warming up
    next_state.circuitReady = armedSync & state.detectEnable;
  end

  // ****************************************
  // registers
  // ****************************************
  // resetn is the power-on reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= '{busState:         BUS_IDLE,
                 regSel:           SEL_NONE,
                 swBrownoutEnable: SW_BOR_EN_INIT,
                 pinPrev:          1'b0,
                 detectEnable:     1'b0,
                 circuitReady:     1'b0,
                 hreadyout:        1'b1,
                 hresp:            HRESP_OKAY,
                 hrdata:           RDATA_ZERO};
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flops
  assign hrdata               = state.hrdata;
  assign hreadyout            = state.hreadyout;
  assign hresp                = state.hresp;
  assign brownoutDetectEnable = state.detectEnable;
  assign brownoutCircuitReady = state.circuitReady;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_swen_bor_init: assert property (brownoutResetEvt |=> state.swBrownoutEnable)
    else $error("sw enable not set by brown-out reset");

  a_swen_mode_on: assert property (
    brownoutModeConfig == MODE_SW_CTRL ##1 brownoutModeConfig == MODE_SW_CTRL
    |-> brownoutDetectEnable == $past(state.swBrownoutEnable))
    else $error("detect enable does not follow sw enable");

  a_mode_ignores_sw: assert property (
    brownoutModeConfig != MODE_SW_CTRL |=> brownoutDetectEnable == $past(brownoutModeConfig[1]))
    else $error("sw enable leaked into fixed mode");

  a_ready_armed: assert property (
    brownoutCircuitReady == ($past(armedSync) && $past(brownoutDetectEnable)))
    else $error("ready bit wrong");

  a_stack_ovf_set: assert property (
    stackOverflowEvt && !brownoutResetEvt |=> flags[STACK_OVF_BIT])
    else $error("stack overflow flag not set");

  a_stack_unf_set: assert property (
    stackUnderflowEvt && !brownoutResetEvt |=> flags[STACK_UNF_BIT])
    else $error("stack underflow flag not set");

  a_window_clear: assert property (
    windowViolationEvt && !brownoutResetEvt |=> !flags[WIN_VIOL_BIT])
    else $error("window flag not cleared");

  a_timeout_clear: assert property (
    watchdogTimeoutEvt && !brownoutResetEvt |=> !flags[WDT_TMO_BIT])
    else $error("timeout flag not cleared");

  a_pin_clear: assert property (
    $fell(pinSync) && !brownoutResetEvt |=> !flags[PIN_RST_BIT])
    else $error("pin flag not cleared");

  a_instr_clear: assert property (
    resetInstrEvt && !brownoutResetEvt |=> !flags[RST_INSTR_BIT])
    else $error("instruction flag not cleared");

  a_por_kept: assert property (
    !wrFlags |=> $stable(flags[POWER_ON_BIT]))
    else $error("power-on flag changed without a write");

  a_bor_clear: assert property (brownoutResetEvt |=> !flags[BROWNOUT_BIT] ##1 1'b1)
    else $error("brown-out flag not cleared");

  a_memory_violation_flag_clear: assert property (
    memViolationEvt && !brownoutResetEvt |=> !memvFlag)
    else $error("memory violation flag not cleared");

  a_reserved_zero: assert property (
    state.busState == BUS_READ_DONE |-> hrdata[31:FLAG_W] == '0)
    else $error("reserved read bits not zero");

  a_hw_over_write: assert property (
    wrFlags && !hwdata[STACK_OVF_BIT] && stackOverflowEvt && !brownoutResetEvt
    |=> flags[STACK_OVF_BIT])
    else $error("firmware write beat hardware set");

  a_read_wait: assert property (
    addrAccept && !hwrite |=> !hreadyout ##1 hreadyout && hresp == HRESP_OKAY)
    else $error("read wait state wrong");

  c_read_flags: cover property (addrAccept && !hwrite && addrSel == SEL_FLAGS);
  c_write_ctrl: cover property (wrCtrl && !hwdata[SW_BOR_EN_BIT]);
  c_hw_and_write: cover property (wrFlags && windowViolationEvt);
  c_ready_high: cover property ($rose(brownoutCircuitReady));
endmodule

// [core/sync_two_flop.sv]
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // first stage feeds only the second stage
  always_comb begin
    next_state        = state;
    next_state.first  = asyncIn;
    next_state.second = state.first;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign syncOut = state.second;
endmodule

// [verif/reset_cause_status_regs_tb.sv]
// self-checking testbench of the power-control register bank
`timescale 1ns/1ps
module reset_cause_status_regs_tb;
  import power_ctrl_pkg::*;

  // ****************************************
  // stimulus, observed outputs and model state
  // ****************************************
  logic        core_clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  modeCfg;
  logic        armed;
  logic        pinN;
  logic [6:0]  evt;         // 0 brown-out, 1 ovf, 2 unf, 3 window, 4 time-out, 5 instr, 6 memory_violation_flag
  logic        detEn;
  logic        cktReady;
  logic [31:0] rd;
  logic [31:0] rng;
  logic [31:0] a;
  logic [31:0] rv;
  logic [11:0] idxList [4];
  logic        mSw;
  logic [7:0]  mFlags;
  logic        mMemv;
  int          error_cnt;
  int          checks;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  reset_cause_status_regs u_reset_cause_status_regs (
    .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .brownoutModeConfig(modeCfg), .brownoutArmed(armed), .externalResetPinN(pinN),
    .brownoutResetEvt(evt[0]), .stackOverflowEvt(evt[1]), .stackUnderflowEvt(evt[2]),
    .windowViolationEvt(evt[3]), .watchdogTimeoutEvt(evt[4]), .resetInstrEvt(evt[5]),
    .memViolationEvt(evt[6]), .brownoutDetectEnable(detEn), .brownoutCircuitReady(cktReady)
  );

  // 200 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ****************************************
  // model, comparison and bus tasks
  // ****************************************
  function automatic logic [31:0] addr_of(input logic [11:0] idx);
    return {18'h0_0000, idx, 2'h0};
  endfunction

  function automatic logic [31:0] next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // only valid once the mode and the armed level have been stable a few cycles
  function automatic logic exp_det();
    return (modeCfg == MODE_SW_CTRL) ? mSw : modeCfg[1];
  endfunction

  function automatic logic [31:0] exp_reg(input logic [31:0] ad);
    if (ad == addr_of(BOR_CTRL_IDX)) return {24'h00_0000, mSw, 6'h00, armed & exp_det()};
    if (ad == addr_of(CAUSE_FLAGS_IDX)) return {24'h00_0000, mFlags};
    if (ad == addr_of(MEMORY_VIOLATION_FLAG_STATUS_IDX)) return {24'h00_0000, 6'h00, mMemv, 1'h0};
    return 32'h0000_0000;
  endfunction

  // hardware events applied after any firmware write, so they win
  task automatic model_evt(input logic [6:0] e);
    if (e[1]) mFlags[7] = 1'b1;
    if (e[2]) mFlags[6] = 1'b1;
    if (e[3]) mFlags[5] = 1'b0;
    if (e[4]) mFlags[4] = 1'b0;
    if (e[5]) mFlags[2] = 1'b0;
    if (e[6]) mMemv = 1'b0;
    if (e[0]) begin
      mSw = 1'b1;
      mFlags = (mFlags & 8'h02) | 8'h3C;
      mMemv = 1'b1;
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single transfer; events e ride in the data phase to collide with a write
  // no wait limit here: only the watchdog ends a hung transfer
  task automatic ahb_xfer(input logic [31:0] ad, input logic wr, input logic [31:0] wd, input logic [6:0] e);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= ad;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    do begin
      @(posedge core_clk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    evt    <= e;
    do begin
      @(posedge core_clk);
    end while (hready !== 1'b1);
    rd = hrdata;
    evt  <= 7'h00;
    hsel <= 1'b0;
    if (wr && ad == addr_of(BOR_CTRL_IDX)) mSw = wd[7];
    if (wr && ad == addr_of(CAUSE_FLAGS_IDX)) mFlags = wd[7:0];
    if (wr && ad == addr_of(MEMORY_VIOLATION_FLAG_STATUS_IDX)) mMemv = wd[1];
    if (wr) model_evt(e);
  endtask

  task automatic rd_chk(input logic [31:0] ad);
    ahb_xfer(ad, 1'b0, 32'h0000_0000, 7'h00);
    check(rd, exp_reg(ad));
  endtask

  task automatic pulse(input logic [6:0] e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= 7'h00;
    model_evt(e);
  endtask

  task automatic model_por();
    mSw = SW_BOR_EN_INIT;
    mFlags = FLAGS_INIT;
    mMemv = MEMORY_VIOLATION_FLAG_INIT;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence and watchdog
  // ****************************************
  // a hang longer than all tests together ends the run
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    end_of_test();
  end

  initial begin
    resetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0000_0000; modeCfg = MODE_SW_CTRL; armed = 1'b1; pinN = 1'b1; evt = 7'h00;
    rng = 32'd88190; error_cnt = 0; checks = 0;
    idxList = '{BOR_CTRL_IDX, CAUSE_FLAGS_IDX, MEMORY_VIOLATION_FLAG_STATUS_IDX, 12'h812};
    model_por();
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd_chk(addr_of(BOR_CTRL_IDX));
    rd_chk(addr_of(CAUSE_FLAGS_IDX));
    rd_chk(addr_of(MEMORY_VIOLATION_FLAG_STATUS_IDX));
    $display("test reset values done");
    // all ones to each register, plus an unmapped and an unaligned place
    foreach (idxList[i]) begin
      a = addr_of(idxList[i]);
      ahb_xfer(a, 1'b1, 32'hFFFF_FFFF, 7'h00);
      rd_chk(a);
    end
    ahb_xfer(32'h0000_2045, 1'b1, 32'hFFFF_FFFF, 7'h00);
    rd_chk(32'h0000_2045);
    $display("test unused bits done");
    ahb_xfer(addr_of(CAUSE_FLAGS_IDX), 1'b1, 32'h0000_003F, 7'h00);
    for (int i = 1; i < 7; i++) begin
      pulse(7'(1 << i));
      rd_chk(addr_of(CAUSE_FLAGS_IDX));
      rd_chk(addr_of(MEMORY_VIOLATION_FLAG_STATUS_IDX));
    end
    $display("test cause events done");
    // pin edge clears once; a rewrite while still low must stick
    pinN <= 1'b0;
    repeat (6) @(posedge core_clk);
    mFlags[3] = 1'b0;
    rd_chk(addr_of(CAUSE_FLAGS_IDX));
    ahb_xfer(addr_of(CAUSE_FLAGS_IDX), 1'b1, 32'h0000_00FF, 7'h00);
    pinN <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd_chk(addr_of(CAUSE_FLAGS_IDX));
    $display("test reset pin done");
    ahb_xfer(addr_of(CAUSE_FLAGS_IDX), 1'b1, 32'h0000_00FF, 7'h3C);
    rd_chk(addr_of(CAUSE_FLAGS_IDX));
    ahb_xfer(addr_of(CAUSE_FLAGS_IDX), 1'b1, 32'h0000_0000, 7'h06);
    rd_chk(addr_of(CAUSE_FLAGS_IDX));
    ahb_xfer(addr_of(MEMORY_VIOLATION_FLAG_STATUS_IDX), 1'b1, 32'h0000_0002, 7'h40);
    rd_chk(addr_of(MEMORY_VIOLATION_FLAG_STATUS_IDX));
    ahb_xfer(addr_of(BOR_CTRL_IDX), 1'b1, 32'h0000_0000, 7'h01);
    rd_chk(addr_of(BOR_CTRL_IDX));
    $display("test write collisions done");
    ahb_xfer(addr_of(CAUSE_FLAGS_IDX), 1'b1, 32'h0000_00C3, 7'h00);
    pulse(7'h01);
    rd_chk(addr_of(CAUSE_FLAGS_IDX));
    rd_chk(addr_of(MEMORY_VIOLATION_FLAG_STATUS_IDX));
    $display("test brown-out reset done");
    // every mode with both enable values, then the circuit disarmed
    for (int i = 0; i < 8; i++) begin
      ahb_xfer(addr_of(BOR_CTRL_IDX), 1'b1, {24'h00_0000, i[0], 7'h00}, 7'h00);
      modeCfg <= i[2:1];
      repeat (6) @(posedge core_clk);
      check({31'h0000_0000, detEn}, {31'h0000_0000, exp_det()});
      check({31'h0000_0000, cktReady}, {31'h0000_0000, armed & exp_det()});
      rd_chk(addr_of(BOR_CTRL_IDX));
    end
    armed <= 1'b0;
    repeat (6) @(posedge core_clk);
    check({31'h0000_0000, cktReady}, 32'h0000_0000);
    rd_chk(addr_of(BOR_CTRL_IDX));
    armed <= 1'b1;
    modeCfg <= MODE_SW_CTRL;
    repeat (6) @(posedge core_clk);
    $display("test brown-out modes done");
    // random writes with random colliding events
    for (int i = 0; i < 40; i++) begin
      a = addr_of(idxList[next_rand() % 3]);
      rv = next_rand() & 32'h0000_007E;
      ahb_xfer(a, 1'b1, next_rand(), rv[6:0]);
      repeat (4) @(posedge core_clk);
      rd_chk(a);
    end
    $display("test random traffic done");
    // power-on reset in mid-run
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    model_por();
    repeat (6) @(posedge core_clk);
    rd_chk(addr_of(BOR_CTRL_IDX));
    rd_chk(addr_of(CAUSE_FLAGS_IDX));
    rd_chk(addr_of(MEMORY_VIOLATION_FLAG_STATUS_IDX));
    $display("test second reset done");
    end_of_test();
  end
endmodule
